// ==== pkg/pig_pkg.sv ====
`default_nettype none
package pig_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int unsigned PIG_ADDR_W = 5;
    localparam logic [4:0]  PIG_OFS_GROUP  = 5'h00;
    localparam logic [4:0]  PIG_OFS_STATUS = 5'h04;
    localparam logic [4:0]  PIG_OFS_STATE  = 5'h08;
    localparam logic [4:0]  PIG_OFS_CONFIG = 5'h0C;
    localparam logic [1:0]  PIG_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PIG_RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int unsigned PIG_GRP_W  = 8;
    localparam int unsigned PIG_ST_W   = 11;
    localparam int unsigned PIG_WDC_W  = 5;
    localparam int unsigned PIG_G_SM   = 0;
    localparam int unsigned PIG_G_WD   = 1;
    localparam int unsigned PIG_G_EPM  = 2;
    localparam int unsigned PIG_G_MON  = 3;
    localparam int unsigned PIG_G_TEMP = 4;
    localparam int unsigned PIG_G_OC   = 5;
    localparam int unsigned PIG_G_SPI  = 6;
    localparam int unsigned PIG_G_CFG  = 7;
    localparam int unsigned PIG_S_SM_FAIL = 0;
    localparam int unsigned PIG_S_SM_DONE = 1;
    localparam int unsigned PIG_S_WD      = 2;
    localparam int unsigned PIG_S_EPM     = 3;
    localparam int unsigned PIG_S_MON     = 4;
    localparam int unsigned PIG_S_OTW     = 5;
    localparam int unsigned PIG_S_OTS     = 6;
    localparam int unsigned PIG_S_OC_REF  = 7;
    localparam int unsigned PIG_S_OC_STBY = 8;
    localparam int unsigned PIG_S_SPI     = 9;
    localparam int unsigned PIG_S_CFG_DBE = 10;
    localparam int unsigned PIG_STA_MISSED  = 0;
    localparam int unsigned PIG_STA_LINE    = 1;
    localparam int unsigned PIG_STA_WDC_LSB = 4;
    localparam int unsigned PIG_CFG_THR_LSB = 0;
    localparam int unsigned PIG_CFG_THR_W   = 4;
    localparam int unsigned PIG_CFG_REC_EN  = 8;
    localparam logic [3:0]  PIG_CFG_THR_RST = 4'h4;
    localparam logic        PIG_CFG_REC_RST = 1'b0;
    localparam logic [4:0]  PIG_WD_STEP     = 5'h02;
    localparam logic [4:0]  PIG_WD_MIN_THR  = 5'h02;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned PIG_CLK_NS      = 20;
    localparam int unsigned PIG_TICK_NS     = 1000;
    localparam int unsigned PIG_TICK_CYC    = (PIG_TICK_NS + PIG_CLK_NS - 1) / PIG_CLK_NS;
    localparam int unsigned PIG_INT_LOW_US  = 100;
    localparam int unsigned PIG_INT_TO_US   = 300;
    localparam int unsigned PIG_INT_HIGH_US = 300;
    localparam int unsigned PIG_INT_LOW_CYC =
        (PIG_INT_LOW_US * 1000 + PIG_CLK_NS - 1) / PIG_CLK_NS;
    localparam int unsigned PIG_INT_TO_CYC  = (PIG_INT_TO_US * 1000) / PIG_CLK_NS;
    localparam int unsigned PIG_INT_HIGH_CYC =
        (PIG_INT_HIGH_US * 1000 + PIG_CLK_NS - 1) / PIG_CLK_NS;
    localparam logic [5:0]  PIG_TICK_LAST  = 6'(PIG_TICK_CYC - 1);
    localparam logic [8:0]  PIG_LOW_TICKS  = 9'(PIG_INT_LOW_CYC / PIG_TICK_CYC);
    localparam logic [8:0]  PIG_TO_TICKS   = 9'(PIG_INT_TO_CYC / PIG_TICK_CYC);
    localparam logic [8:0]  PIG_HIGH_TICKS = 9'(PIG_INT_HIGH_CYC / PIG_TICK_CYC);
    // ----------------------------------------------------------------
    // types and helpers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIG_ST_IDLE     = 2'h0,
        PIG_ST_LOW_MIN  = 2'h1,
        PIG_ST_LOW_WAIT = 2'h3,
        PIG_ST_HIGH     = 2'h2
    } pig_state_e;

    function automatic logic [31:0] pig_strb_mask(input logic [3:0] strb);
        pig_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction
endpackage
`default_nettype wire

// ==== logic/pig_flag_bank.sv ====
`default_nettype none
module pig_flag_bank
    import pig_pkg::*;
#(
    parameter int unsigned W = 8
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_b_i,
    // set and clear strobes
    input  wire logic [W-1:0] set_i,
    input  wire logic [W-1:0] clr_i,
    // latched flags
    output logic      [W-1:0] flag_o
);
    for (genvar i = 0; i < W; i++) begin : g_bit
        // set wins so an event in the clearing cycle is kept
        always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                flag_o[i] <= 1'b0;
            end else if (set_i[i]) begin
                flag_o[i] <= 1'b1;
            end else if (clr_i[i]) begin
                flag_o[i] <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/pig_irq_gen.sv ====
// How it works
// - state machine transition failure or success raises an interrupt request
// - watchdog error requests only if threshold above 2 and not exceeded
// - error pin fault requests only with recovery enabled and delay unexpired
// - monitor, temperature, overcurrent, serial and config errors also request
// - one idle-high interrupt output; sources always enabled, never maskable
// - condition drives the line low for at least 100 us
// - line released once group flags clear, after 100 us, by 300 us
// - uncleared flags hold line low to timeout; missed flag records it
// - missed flag clears whenever the line goes low
// - stale clear leaves line low to timeout; missed flag reports it
// - after release the line stays high at least 300 us
// - events during the high time give a new pulse afterward
// - flags clear only by writing one; writing zero does nothing
// - group flags and detailed status flags, both write-one-to-clear
// - no pulse while the controller reset is held; status still set
// - low timeout halts in the low wait phase while controller reset is held
// - each invalid watchdog trigger adds two to the error counter, saturating at 31
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none
module pig_irq_gen
    import pig_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_b_i,
    // interrupt sources
    input  wire logic                  sm_trans_fail_i,
    input  wire logic                  sm_trans_done_i,
    input  wire logic                  wd_invalid_i,
    input  wire logic                  wd_valid_i,
    input  wire logic                  epm_err_i,
    input  wire logic                  epm_recovery_expired_i,
    input  wire logic                  mon_irq_req_i,
    input  wire logic                  otw_i,
    input  wire logic                  ots_i,
    input  wire logic                  oc_ref_i,
    input  wire logic                  oc_stby_i,
    input  wire logic                  spi_err_i,
    input  wire logic                  cfg_dbe_i,
    input  wire logic                  mcu_reset_out_b_i,
    // interrupt line
    output logic                       int_n_o,
    // axi4-lite write
    input  wire logic [PIG_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                  s_axi_awvalid_i,
    output logic                       s_axi_awready_o,
    input  wire logic [31:0]           s_axi_wdata_i,
    input  wire logic [3:0]            s_axi_wstrb_i,
    input  wire logic                  s_axi_wvalid_i,
    output logic                       s_axi_wready_o,
    output logic [1:0]                 s_axi_bresp_o,
    output logic                       s_axi_bvalid_o,
    input  wire logic                  s_axi_bready_i,
    // axi4-lite read
    input  wire logic [PIG_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                  s_axi_arvalid_i,
    output logic                       s_axi_arready_o,
    output logic [31:0]                s_axi_rdata_o,
    output logic [1:0]                 s_axi_rresp_o,
    output logic                       s_axi_rvalid_o,
    input  wire logic                  s_axi_rready_i
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    pig_state_e             state_q, state_d;
    logic [5:0]             presc_q, presc_d;
    logic [8:0]             us_q, us_d;
    logic                   arm_q, arm_d;
    logic                   missed_q, missed_d;
    logic                   int_n_d;
    logic [PIG_WDC_W-1:0]   wdc_q, wdc_d;
    logic [3:0]             thr_q;
    logic                   rec_en_q;
    logic [PIG_GRP_W-1:0]   grp_q, grp_set, grp_clr;
    logic [PIG_ST_W-1:0]    st_q, st_set, st_clr;
    logic                   aw_hold_q, w_hold_q;
    logic [PIG_ADDR_W-1:0]  awaddr_q;
    logic [31:0]            wdata_q, wmask_q;
    wire                    rot_rel = mcu_reset_out_b_i;
    wire                    low_now = (state_q == PIG_ST_LOW_MIN) ||
                                      (state_q == PIG_ST_LOW_WAIT);
    wire                    tick    = (presc_q == PIG_TICK_LAST);
    wire                    run     = !((state_q == PIG_ST_LOW_WAIT) && !rot_rel);
    wire                    to_hit  = run && tick && (us_q == PIG_TO_TICKS - 9'h001);
    wire                    start   = (state_q == PIG_ST_IDLE) &&
                                      (state_d == PIG_ST_LOW_MIN);
    wire                    restart = (state_d != state_q) &&
                                      ((state_d == PIG_ST_LOW_MIN) ||
                                       (state_d == PIG_ST_HIGH));

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ----------------------------------------------------------------
    // source qualification
    // ----------------------------------------------------------------
    wire [5:0] wdc_after = {1'b0, wdc_q} + {1'b0, PIG_WD_STEP};
    wire       wd_req    = wd_invalid_i && ({1'b0, thr_q} > PIG_WD_MIN_THR) &&
                           (wdc_after <= {2'h0, thr_q});
    wire       epm_req   = epm_err_i && rec_en_q && !epm_recovery_expired_i;

    // done also tells the host that full serial speed is allowed
    assign st_set[PIG_S_SM_FAIL] = sm_trans_fail_i;
    assign st_set[PIG_S_SM_DONE] = sm_trans_done_i;
    assign st_set[PIG_S_WD]      = wd_req;
    assign st_set[PIG_S_EPM]     = epm_req;
    assign st_set[PIG_S_MON]     = mon_irq_req_i;
    assign st_set[PIG_S_OTW]     = otw_i;
    assign st_set[PIG_S_OTS]     = ots_i;
    assign st_set[PIG_S_OC_REF]  = oc_ref_i;
    assign st_set[PIG_S_OC_STBY] = oc_stby_i;
    assign st_set[PIG_S_SPI]     = spi_err_i;
    assign st_set[PIG_S_CFG_DBE] = cfg_dbe_i;

    // no mask stage exists: every source reaches the group level
    // events during controller reset reach the status level only
    wire [PIG_GRP_W-1:0] grp_evt = {
        st_set[PIG_S_CFG_DBE],
        st_set[PIG_S_SPI],
        st_set[PIG_S_OC_REF] | st_set[PIG_S_OC_STBY],
        st_set[PIG_S_OTW] | st_set[PIG_S_OTS],
        st_set[PIG_S_MON],
        st_set[PIG_S_EPM],
        st_set[PIG_S_WD],
        st_set[PIG_S_SM_FAIL] | st_set[PIG_S_SM_DONE]
    };
    assign grp_set = rot_rel ? grp_evt : '0;

    // ----------------------------------------------------------------
    // watchdog error counter
    // ----------------------------------------------------------------
    // invalid wins over valid; saturate rather than wrap
    assign wdc_d = wd_invalid_i ? ((wdc_after[5] || wdc_after[4:0] < wdc_q) ?
                                   5'h1F : wdc_after[4:0]) :
                   (wd_valid_i && wdc_q != 5'h00) ? wdc_q - 5'h01 : wdc_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdc_q <= 5'h00;
        end else begin
            wdc_q <= wdc_d;
        end
    end

    // ----------------------------------------------------------------
    // flag banks
    // ----------------------------------------------------------------
    wire wr_fire  = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
    wire [31:0] wbits = wdata_q & wmask_q;
    assign grp_clr = (wr_fire && awaddr_q == PIG_OFS_GROUP) ?
                     wbits[PIG_GRP_W-1:0] : '0;
    assign st_clr  = (wr_fire && awaddr_q == PIG_OFS_STATUS) ?
                     wbits[PIG_ST_W-1:0] : '0;

    pig_flag_bank #(.W(PIG_GRP_W)) u_grp (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .set_i     (grp_set),
        .clr_i     (grp_clr),
        .flag_o    (grp_q)
    );

    pig_flag_bank #(.W(PIG_ST_W)) u_st (
        .ref_clk_i (ref_clk_i),
        .rst_b_i   (rst_b_i),
        .set_i     (st_set),
        .clr_i     (st_clr),
        .flag_o    (st_q)
    );

    // ----------------------------------------------------------------
    // line sequencer
    // ----------------------------------------------------------------
    wire grp_clean = (grp_q == '0);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PIG_ST_IDLE: begin
                if (arm_q && rot_rel) begin
                    state_d = PIG_ST_LOW_MIN;
                end
            end
            PIG_ST_LOW_MIN: begin
                if (tick && us_q == PIG_LOW_TICKS - 9'h001) begin
                    state_d = PIG_ST_LOW_WAIT;
                end
            end
            PIG_ST_LOW_WAIT: begin
                // only groups matter; a stale clear keeps it low
                if (grp_clean || to_hit) begin
                    state_d = PIG_ST_HIGH;
                end
            end
            PIG_ST_HIGH: begin
                if (tick && us_q == PIG_HIGH_TICKS - 9'h001) begin
                    state_d = PIG_ST_IDLE;
                end
            end
        endcase
    end

    // timeout halts while the controller is held in reset during the low wait
    assign presc_d = restart ? 6'h00 : !run ? presc_q :
                     tick ? 6'h00 : presc_q + 6'h01;
    assign us_d    = restart ? 9'h000 : (run && tick) ? us_q + 9'h001 : us_q;

    // events seen while low belong to that pulse or end up as missed
    assign arm_d    = ((|grp_set) && !low_now) || (arm_q && !start);
    assign missed_d = ((state_q == PIG_ST_LOW_WAIT) && to_hit && !grp_clean) ||
                      (missed_q && !start);
    assign int_n_d  = !((state_d == PIG_ST_LOW_MIN) ||
                        (state_d == PIG_ST_LOW_WAIT));

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q  <= PIG_ST_IDLE;
            presc_q  <= 6'h00;
            us_q     <= 9'h000;
            arm_q    <= 1'b0;
            missed_q <= 1'b0;
            int_n_o  <= 1'b1;
        end else begin
            state_q  <= state_d;
            presc_q  <= presc_d;
            us_q     <= us_d;
            arm_q    <= arm_d;
            missed_q <= missed_d;
            int_n_o  <= int_n_d;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    wire aw_take   = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take    = s_axi_wvalid_i && s_axi_wready_o;
    wire aw_hold_d = aw_take || (aw_hold_q && !wr_fire);
    wire w_hold_d  = w_take || (w_hold_q && !wr_fire);
    wire ar_take   = s_axi_arvalid_i && s_axi_arready_o;
    wire rvalid_d  = ar_take || (s_axi_rvalid_o && !s_axi_rready_i);
    wire bvalid_d  = wr_fire || (s_axi_bvalid_o && !s_axi_bready_i);
    wire [31:0] cfg_word = {23'h0, rec_en_q, 4'h0, thr_q};
    wire [31:0] sta_word = {23'h0, wdc_q, 2'h0, int_n_o, missed_q};
    wire        ar_map   = (s_axi_araddr_i[1:0] == 2'h0) &&
                           (s_axi_araddr_i < 5'h10);
    wire        aw_map   = (awaddr_q[1:0] == 2'h0) && (awaddr_q < 5'h10);
    wire [31:0] rd_word  = (s_axi_araddr_i == PIG_OFS_GROUP)  ? 32'(grp_q) :
                           (s_axi_araddr_i == PIG_OFS_STATUS) ? 32'(st_q)  :
                           (s_axi_araddr_i == PIG_OFS_STATE)  ? sta_word   :
                           (s_axi_araddr_i == PIG_OFS_CONFIG) ? cfg_word   : 32'h0;
    wire        cfg_wr   = wr_fire && awaddr_q == PIG_OFS_CONFIG;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_hold_q       <= 1'b0;
            w_hold_q        <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
        end else begin
            aw_hold_q       <= aw_hold_d;
            w_hold_q        <= w_hold_d;
            s_axi_awready_o <= !aw_hold_d;
            s_axi_wready_o  <= !w_hold_d;
            s_axi_bvalid_o  <= bvalid_d;
            s_axi_arready_o <= !rvalid_d;
            s_axi_rvalid_o  <= rvalid_d;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            awaddr_q      <= 5'h00;
            wdata_q       <= 32'h0;
            wmask_q       <= 32'h0;
            s_axi_bresp_o <= PIG_RESP_OKAY;
            s_axi_rresp_o <= PIG_RESP_OKAY;
            s_axi_rdata_o <= 32'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr_i;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata_i;
                wmask_q <= pig_strb_mask(s_axi_wstrb_i);
            end
            if (wr_fire) begin
                s_axi_bresp_o <= aw_map ? PIG_RESP_OKAY : PIG_RESP_SLVERR;
            end
            if (ar_take) begin
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= ar_map ? PIG_RESP_OKAY : PIG_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            thr_q    <= PIG_CFG_THR_RST;
            rec_en_q <= PIG_CFG_REC_RST;
        end else if (cfg_wr) begin
            thr_q    <= (thr_q & ~wmask_q[3:0]) | wbits[3:0];
            rec_en_q <= wmask_q[PIG_CFG_REC_EN] ? wdata_q[PIG_CFG_REC_EN] : rec_en_q;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    localparam int unsigned A_LOW_MIN  = PIG_INT_LOW_CYC;
    localparam int unsigned A_HIGH_MIN = PIG_INT_HIGH_CYC;
    logic [15:0] low_cnt_q, high_cnt_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_cnt_q  <= 16'h0000;
            high_cnt_q <= 16'hFFFF;
        end else begin
            low_cnt_q  <= int_n_o ? 16'h0000 : low_cnt_q + 16'(low_cnt_q != 16'hFFFF);
            high_cnt_q <= !int_n_o ? 16'h0000 : high_cnt_q + 16'(high_cnt_q != 16'hFFFF);
        end
    end

    sequence s_low_start;
        $fell(int_n_o);
    endsequence
    sequence s_wait_clean;
        state_q == PIG_ST_LOW_WAIT && grp_clean;
    endsequence

    a_low_min_width: assert property ($rose(int_n_o) |-> low_cnt_q >= A_LOW_MIN)
        else $error("interrupt low pulse too short");
    a_high_gap_min: assert property (s_low_start |-> high_cnt_q >= A_HIGH_MIN)
        else $error("interrupt high gap too short");
    a_missed_on_low: assert property (s_low_start |-> !missed_q)
        else $error("missed flag not cleared at pulse start");
    a_release_clean: assert property (s_wait_clean |=> state_q == PIG_ST_HIGH ##1 int_n_o)
        else $error("line not released after group flags cleared");
    a_timeout_missed: assert property ((state_q == PIG_ST_LOW_WAIT && to_hit && !grp_clean)
        |=> missed_q && state_q == PIG_ST_HIGH)
        else $error("timeout did not record missed event");
    a_no_pulse_rst: assert property ((state_q == PIG_ST_IDLE && !rot_rel)
        |=> state_q == PIG_ST_IDLE && int_n_o)
        else $error("pulse started during controller reset");
    a_zero_write_keep: assert property ((grp_clr == '0) |=>
        (grp_q & $past(grp_q)) == $past(grp_q))
        else $error("group flag lost without a one written");
    a_wd_gate_thr: assert property ((wd_invalid_i && thr_q <= 4'h2 && !grp_q[PIG_G_WD])
        |=> !grp_q[PIG_G_WD])
        else $error("watchdog interrupt below threshold limit");
    a_wd_count_step: assert property ((wd_invalid_i && wdc_q <= 5'h1D)
        |=> wdc_q == $past(wdc_q) + PIG_WD_STEP)
        else $error("watchdog counter did not add two");
    a_epm_gate_off: assert property ((epm_err_i && !rec_en_q && !st_q[PIG_S_EPM])
        |=> !st_q[PIG_S_EPM])
        else $error("error pin interrupt with recovery disabled");
    a_status_in_rst: assert property ((otw_i && !rot_rel) |=> st_q[PIG_S_OTW])
        else $error("status not set during controller reset");
endmodule
`default_nettype wire

// ==== sim/pig_mcu_model.sv ====
`default_nettype none
module pig_mcu_model (
    // clock, reset and bench control
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        rel_i,
    input  wire logic        int_n_i,
    // controller side
    output logic             mcu_reset_out_b_o,
    output logic      [15:0] low_len_o,
    output logic      [15:0] high_len_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        prev_q;
    logic [15:0] cnt_q;
    // controller reset follows the bench request one cycle late
    // widths are measured in cycles of the level just ended
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {mcu_reset_out_b_o, prev_q, cnt_q, low_len_o, high_len_o} <= {2'b01, 48'h0};
        end else begin
            mcu_reset_out_b_o <= rel_i;
            prev_q <= int_n_i;
            cnt_q <= (int_n_i != prev_q) ? 16'h0001 : cnt_q + 16'h0001;
            if (int_n_i && !prev_q) low_len_o <= cnt_q;
            if (!int_n_i && prev_q) high_len_o <= cnt_q;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module testbench;
    import pig_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, rel = 0, rexp = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [11:0] s  = '0;
    logic [4:0]  aw = '0, ar = '0;
    logic [31:0] wd = '0;
    wire logic awr, wr, bv, arr, rv, int_n, mrst;
    wire logic [1:0]  br, rr;
    wire logic [31:0] rdat;
    wire logic [15:0] lo, hi;
    int n_fail = 0, checks = 0;
    initial forever #10 clk = ~clk;
    pig_irq_gen pig_irq_gen_i (.ref_clk_i(clk), .rst_b_i(rst_b), .sm_trans_fail_i(s[0]),
        .sm_trans_done_i(s[1]), .wd_invalid_i(s[2]), .wd_valid_i(s[3]), .epm_err_i(s[4]),
        .epm_recovery_expired_i(rexp), .mon_irq_req_i(s[5]), .otw_i(s[6]), .ots_i(s[7]),
        .oc_ref_i(s[8]), .oc_stby_i(s[9]), .spi_err_i(s[10]), .cfg_dbe_i(s[11]),
        .mcu_reset_out_b_i(mrst), .int_n_o(int_n), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
        .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre));
    pig_mcu_model pig_mcu_model_i (.ref_clk_i(clk), .rst_b_i(rst_b), .rel_i(rel),
        .int_n_i(int_n), .mcu_reset_out_b_o(mrst), .low_len_o(lo), .high_len_o(hi));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // bus cycles and stimulus helpers
    // ------------------------------------------------------------
    task automatic wr32(input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        {aw, wd, awv, wv, bre} <= {a, d, 3'b111};
        for (i = 0; i < 99 && !bv; i++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end
        bre <= 1'b0;
        if (i == 99) begin n_fail++; end_of_test; end
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        int i;
        @(posedge clk);
        {ar, arv, rre} <= {a, 2'b11};
        for (i = 0; i < 99 && !rv; i++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end
        rre <= 1'b0;
        if (i == 99) begin n_fail++; end_of_test; end
        `CHK(rdat, e)
        `CHK(rr, (a < 5'h10) ? PIG_RESP_OKAY : PIG_RESP_SLVERR)
    endtask
    task automatic ev(input int b);
        @(posedge clk); s[b] <= 1'b1;
        @(posedge clk); s[b] <= 1'b0;
    endtask
    // waits for a line level, then two more edges; the partner's width lands one edge after the change
    task automatic wl(input logic v);
        int i;
        for (i = 0; i < 40000 && int_n !== v; i++) @(posedge clk);
        if (i == 40000) begin n_fail++; end_of_test; end
        repeat (2) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_held;
        rd(PIG_OFS_CONFIG, 32'h0000_0004); rd(PIG_OFS_STATE, 32'h0000_0002);
        rd(5'h10, 32'h0000_0000);
        ev(6); repeat (20) @(posedge clk);
        `CHK(int_n, 1'b1)
        rd(PIG_OFS_STATUS, 32'h0000_0020); rd(PIG_OFS_GROUP, 32'h0);
        $display("reset and held-reset test done");
    endtask
    // no command goes out after the transition request until the line is low
    task automatic t_pulse_gap;
        rel <= 1'b1; ev(1); repeat (3) @(posedge clk);
        `CHK(int_n, 1'b0)
        wr32(PIG_OFS_GROUP, 32'h0); rd(PIG_OFS_GROUP, 32'h1);
        rd(PIG_OFS_STATUS, 32'h0000_0022); wr32(PIG_OFS_GROUP, 32'hFF);
        rd(PIG_OFS_GROUP, 32'h0); wl(1);
        `CHK(lo >= 16'd5000 && lo <= 16'd5005, 1'b1)
        // event inside the high gap must give a pulse once the gap is over
        ev(8); wl(0);
        `CHK(hi >= 16'd15000 && hi <= 16'd15005, 1'b1)
        wl(1); rd(PIG_OFS_STATE, 32'h0000_0003);
        `CHK(lo >= 16'd15000 && lo <= 16'd15005, 1'b1)
        wr32(PIG_OFS_GROUP, 32'hFF); wr32(PIG_OFS_STATUS, 32'h7FF);
        $display("pulse, timeout and gap test done");
    endtask
    task automatic t_watchdog;
        ev(2); wl(0); rd(PIG_OFS_STATE, 32'h0000_0020);
        ev(2); wr32(PIG_OFS_GROUP, 32'h02); ev(2); rd(PIG_OFS_GROUP, 32'h0);
        rd(PIG_OFS_STATE, 32'h0000_0060); ev(3); rd(PIG_OFS_STATE, 32'h0000_0050);
        wr32(PIG_OFS_CONFIG, 32'h2); ev(2); rd(PIG_OFS_GROUP, 32'h0);
        $display("watchdog test done");
    endtask
    task automatic t_sources;
        int k;
        ev(4); rd(PIG_OFS_GROUP, 32'h0); wr32(PIG_OFS_CONFIG, 32'h104);
        ev(4); rd(PIG_OFS_GROUP, 32'h04); wr32(PIG_OFS_GROUP, 32'h04);
        rexp <= 1'b1; ev(4); rd(PIG_OFS_GROUP, 32'h0);
        wr32(PIG_OFS_STATUS, 32'h7FF);
        for (k = 4; k < 12; k++) begin
            ev(k == 4 ? 0 : k); rd(PIG_OFS_STATUS, k == 4 ? 32'h1 : 32'(1) << (k - 1));
            wr32(PIG_OFS_STATUS, 32'h7FF);
        end
        rd(PIG_OFS_GROUP, 32'hF9);
        // controller reset held 1000 cycles inside the wait stretches the timeout
        repeat (5100) @(posedge clk); rel <= 1'b0;
        repeat (1000) @(posedge clk); rel <= 1'b1; wl(1);
        `CHK(lo >= 16'd16000 && lo <= 16'd16005, 1'b1)
        $display("source test done");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_held();
        t_pulse_gap();
        t_watchdog();
        t_sources();
        end_of_test();
    end
endmodule
`default_nettype wire
